// file: core/tsw_ctrl.sv
// switch control register, connection memory and its bulk loader behind apb
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tsw_ctrl
   import tsw_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // frame and pins
   input wire logic frame_pulse,
   input wire logic output_drive_pin,
   input wire logic frame_eval_complete,
   // datapath side
   input wire logic [CM_AW-1:0] tx_slot,
   output tsw_cm_s tx_conn,
   output logic tx_oe,
   output logic tx_loop,
   output logic [3:0] rate_select,
   output logic frame_eval_run,
   output logic bulk_busy
);
   localparam int FRAME_CYC = (FRAME_NS + CLK_NS - 1) / CLK_NS;
   localparam int BULK_CYC = BULK_FRAMES * FRAME_CYC;

   logic [15:0] ctrl_ff;
   logic [15:0] pend_ff;
   logic pend_vld_ff;
   logic [15:0] cm_mem [CM_DEPTH];
   logic [CM_AW-1:0] cm_idx_ff;
   logic [CM_AW-1:0] load_ptr_ff;
   logic [17:0] bulk_cnt_ff;
   tsw_bulk_e bulk_ff;
   logic begin_q_ff;
   logic eval_q_ff;
   logic eval_ff;
   logic drive_s;
   logic fp_s;
   logic fp_q_ff;
   logic frame_edge;
   logic wr_acc;
   logic rd_setup;
   logic [15:0] cm_rd;
   logic [15:0] cm_tx;

   // the drive pin and frame pulse come from outside the clock domain
   tsw_sync u_sync_drive (
      .pclk(pclk),
      .presetn(presetn),
      .din(output_drive_pin),
      .dout(drive_s)
   );
   tsw_sync u_sync_fp (
      .pclk(pclk),
      .presetn(presetn),
      .din(frame_pulse),
      .dout(fp_s)
   );

   // frame boundary is the rising edge of the filtered frame pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fp_q_ff <= 1'b0;
      else
         fp_q_ff <= fp_s;
   end
   assign frame_edge = fp_s & ~fp_q_ff;

   // zero wait state slave, every address answers
   assign wr_acc = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & (paddr != ADDR_CTRL) & (paddr != ADDR_CM_IDX)
      & (paddr != ADDR_CM_DATA);

   // control writes are held pending and applied at the next frame boundary
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_ff <= CTRL_RESET;
         pend_vld_ff <= 1'b0;
      end
      else if (wr_acc && paddr == ADDR_CTRL)
      begin
         pend_ff <= pwdata[15:0] & CTRL_WMASK; // bit 10 forced zero
         pend_vld_ff <= 1'b1;
      end
      else if (frame_edge)
         pend_vld_ff <= 1'b0;
   end

   // control register; hardware clear of begin wins over the pending write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_ff <= CTRL_RESET;
      else
      begin
         if (frame_edge && pend_vld_ff)
            ctrl_ff <= pend_ff;
         if (bulk_ff == TSW_DONE)
            ctrl_ff[CTRL_BEGIN] <= 1'b0;
      end
   end

   // begin edge detector
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         begin_q_ff <= 1'b0;
      else
         begin_q_ff <= ctrl_ff[CTRL_BEGIN];
   end

   // bulk load sequencer: edge of begin while armed, then walk all entries
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bulk_ff <= TSW_IDLE;
         load_ptr_ff <= '0;
         bulk_cnt_ff <= '0;
      end
      else
      begin
         case (bulk_ff)
            TSW_IDLE:
            begin
               bulk_cnt_ff <= '0;
               load_ptr_ff <= '0;
               if (ctrl_ff[CTRL_BEGIN] && !begin_q_ff && ctrl_ff[CTRL_ARM])
                  bulk_ff <= TSW_LOAD;
            end
            TSW_LOAD:
            begin
               bulk_cnt_ff <= bulk_cnt_ff + 18'h00001;
               load_ptr_ff <= load_ptr_ff + 12'h001;
               if (load_ptr_ff == 12'hFFF)
                  bulk_ff <= TSW_WAIT;
            end
            TSW_WAIT:
            begin
               // completion is reported at the two-frame mark, as software expects
               bulk_cnt_ff <= bulk_cnt_ff + 18'h00001;
               if (bulk_cnt_ff >= 18'(BULK_CYC - 2))
                  bulk_ff <= TSW_DONE;
            end
            default:
               bulk_ff <= TSW_IDLE;
         endcase
      end
   end
   assign bulk_busy = (bulk_ff != TSW_IDLE);

   // connection memory: bulk load has priority over software writes
   always_ff @(posedge pclk)
   begin
      if (bulk_ff == TSW_LOAD)
         cm_mem[load_ptr_ff] <= {ctrl_ff[CTRL_BPV_HI:CTRL_BPV_LO], 13'h0000};
      else if (wr_acc && paddr == ADDR_CM_DATA)
         cm_mem[cm_idx_ff] <= pwdata[15:0];
   end

   // memory index register for software access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cm_idx_ff <= '0;
      else if (wr_acc && paddr == ADDR_CM_IDX)
         cm_idx_ff <= pwdata[CM_AW-1:0];
   end

   assign cm_rd = cm_mem[cm_idx_ff];
   assign cm_tx = cm_mem[tx_slot];

   // read data captured in the setup cycle so the access cycle shows a flop;
   // a frame apply between the two cycles is seen by the next read only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_setup && paddr == ADDR_CTRL)
         prdata <= {16'h0000, ctrl_ff};
      else if (rd_setup && paddr == ADDR_CM_IDX)
         prdata <= {20'h00000, cm_idx_ff};
      else if (rd_setup && paddr == ADDR_CM_DATA)
         prdata <= {16'h0000, cm_rd};
      else
         prdata <= 32'h00000000;
   end

   // frame evaluation runs from start edge until complete flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eval_q_ff <= 1'b0;
         eval_ff <= 1'b0;
      end
      else
      begin
         eval_q_ff <= ctrl_ff[CTRL_EVAL];
         if (frame_eval_complete)
            eval_ff <= 1'b0;
         else if (ctrl_ff[CTRL_EVAL] && !eval_q_ff)
            eval_ff <= 1'b1;
      end
   end
   assign frame_eval_run = eval_ff;

   // per-channel datapath controls, registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_conn <= '0;
         tx_oe <= 1'b0;
         tx_loop <= 1'b0;
      end
      else
      begin
         tx_conn.channel_loopback <= cm_tx[CM_CHANNEL_LOOPBACK];
         tx_conn.mode <= cm_tx[CM_MODE_HI:CM_MODE_LO];
         tx_conn.src_stream <= cm_tx[CM_SRC_HI:CM_SRC_LO];
         tx_conn.src_chan <= cm_tx[CM_CHN_HI:0];
         // drivers off when pin low and standby clear, or mode is 11
         tx_oe <= (drive_s | ctrl_ff[CTRL_STBY])
            & (cm_tx[CM_MODE_HI:CM_MODE_LO] != MODE_HIZ);
         // loopback only at the three lowest uniform rates
         tx_loop <= cm_tx[CM_CHANNEL_LOOPBACK] & (ctrl_ff[CTRL_RATE_HI:0] <= 4'h2);
      end
   end
   assign rate_select = ctrl_ff[CTRL_RATE_HI:0];

   // begin clears exactly after the done state
   property p_begin_clear;
      @(posedge pclk) disable iff (!presetn)
      bulk_ff == TSW_DONE |=> !ctrl_ff[CTRL_BEGIN];
   endproperty
   a_begin_clear: assert property (p_begin_clear) else $error("begin not cleared");

   // load starts only from rising begin while armed
   property p_load_start;
      @(posedge pclk) disable iff (!presetn)
      $rose(bulk_ff == TSW_LOAD) |-> $past(ctrl_ff[CTRL_ARM]) && $past(ctrl_ff[CTRL_BEGIN])
         && !$past(begin_q_ff);
   endproperty
   a_load_start: assert property (p_load_start) else $error("bulk load bad start");

   // disarmed never enters load
   property p_arm;
      @(posedge pclk) disable iff (!presetn)
      bulk_ff == TSW_IDLE && !ctrl_ff[CTRL_ARM] |=> bulk_ff != TSW_LOAD;
   endproperty
   a_arm: assert property (p_arm) else $error("load while disarmed");

   // high impedance mode never drives
   property p_hiz;
      @(posedge pclk) disable iff (!presetn)
      tx_conn.mode == MODE_HIZ |-> !tx_oe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("hiz channel driven");

   // pin low and standby low keep drivers off
   property p_stby;
      @(posedge pclk) disable iff (!presetn)
      !drive_s && !ctrl_ff[CTRL_STBY] |=> !tx_oe;
   endproperty
   a_stby: assert property (p_stby) else $error("driven in standby");

   // control only changes at a frame edge or by the begin clear
   property p_frame_apply;
      @(posedge pclk) disable iff (!presetn)
      !frame_edge && bulk_ff != TSW_DONE |=> $stable(ctrl_ff);
   endproperty
   a_frame_apply: assert property (p_frame_apply) else $error("control changed mid-frame");

   // bit 10 always reads zero
   property p_rsvd;
      @(posedge pclk) disable iff (!presetn)
      !ctrl_ff[CTRL_RSVD];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

   // evaluation stops the cycle after complete
   property p_eval_stop;
      @(posedge pclk) disable iff (!presetn)
      frame_eval_complete |=> !frame_eval_run;
   endproperty
   a_eval_stop: assert property (p_eval_stop) else $error("evaluation not stopped");

   // loopback never at higher rates
   property p_loop_rate;
      @(posedge pclk) disable iff (!presetn)
      tx_loop |-> $past(ctrl_ff[CTRL_RATE_HI:0]) <= 4'h2;
   endproperty
   a_loop_rate: assert property (p_loop_rate) else $error("loopback at bad rate");
endmodule : tsw_ctrl

// file: core/tsw_pkg.sv
// package of constants and types for the switch control and connection memory block
package tsw_pkg;
   // memory geometry: 32 streams x 128 channels
   localparam int CM_AW = 12;
   localparam int CM_DEPTH = 4096;
   // apb byte addresses
   localparam logic [15:0] ADDR_CTRL = 16'h0000;
   localparam logic [15:0] ADDR_CM_IDX = 16'h0004;
   localparam logic [15:0] ADDR_CM_DATA = 16'h0008;
   // control field positions
   localparam int CTRL_ARM = 11;
   localparam int CTRL_RSVD = 10;
   localparam int CTRL_BPV_HI = 9;
   localparam int CTRL_BPV_LO = 7;
   localparam int CTRL_BEGIN = 6;
   localparam int CTRL_STBY = 5;
   localparam int CTRL_EVAL = 4;
   localparam int CTRL_RATE_HI = 3;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'h0BFF;
   // connection memory field positions
   localparam int CM_CHANNEL_LOOPBACK = 15;
   localparam int CM_MODE_HI = 14;
   localparam int CM_MODE_LO = 13;
   localparam int CM_SRC_HI = 12;
   localparam int CM_SRC_LO = 8;
   localparam int CM_CHN_HI = 7;
   localparam logic [1:0] MODE_HIZ = 2'h3;
   // bulk load: two frames of 125 us
   localparam int FRAME_NS = 125000;
   localparam int CLK_NS = 10;
   localparam int BULK_FRAMES = 2;
   typedef enum logic [1:0] {TSW_IDLE = 2'b00, TSW_WAIT = 2'b01, TSW_LOAD = 2'b11,
      TSW_DONE = 2'b10} tsw_bulk_e;
   typedef struct packed {
      logic channel_loopback;
      logic [1:0] mode;
      logic [4:0] src_stream;
      logic [7:0] src_chan;
   } tsw_cm_s;
endpackage : tsw_pkg

// file: core/tsw_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module tsw_sync
   import tsw_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // asynchronous level in, filtered level out
   input wire logic din,
   output logic dout
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   // stage one is read only by stage two
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   // output only changes once stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dout <= 1'b0;
      else if (s2_ff == s3_ff)
         dout <= s3_ff;
   end
endmodule : tsw_sync

// file: test/tsw_ctrl_tb_top.sv
// self-checking bench for the switch control register and connection memory
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_count++; \
   $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tsw_ctrl_tb_top
   import tsw_pkg::*;
;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [15:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic frame_pulse;
   logic output_drive_pin;
   logic frame_eval_complete;
   logic [CM_AW-1:0] tx_slot;
   tsw_cm_s tx_conn;
   logic tx_oe;
   logic tx_loop;
   logic [3:0] rate_select;
   logic frame_eval_run;
   logic bulk_busy;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int t0;
   int n;
   logic [31:0] rdat;
   logic rerr;
   tsw_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_pulse(frame_pulse), .output_drive_pin(output_drive_pin),
      .frame_eval_complete(frame_eval_complete), .tx_slot(tx_slot), .tx_conn(tx_conn),
      .tx_oe(tx_oe), .tx_loop(tx_loop), .rate_select(rate_select),
      .frame_eval_run(frame_eval_run), .bulk_busy(bulk_busy));
   // 100 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   // one apb transfer; the leading edge keeps back-to-back calls from double driving
   task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50) `CHK("pready", 1'b1, pready)
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // write one connection memory word through index and data registers
   task cmw(input logic [11:0] idx, input logic [15:0] d);
      apb(1'b1, ADDR_CM_IDX, {20'h00000, idx});
      apb(1'b1, ADDR_CM_DATA, {16'h0000, d});
   endtask : cmw
   // read one connection memory word into rdat
   task cmr(input logic [11:0] idx);
      apb(1'b1, ADDR_CM_IDX, {20'h00000, idx});
      apb(1'b0, ADDR_CM_DATA, 32'h00000000);
   endtask : cmr
   // frame start pulse, long enough to pass the synchroniser
   task frame();
      @(posedge pclk);
      frame_pulse <= 1'b1;
      repeat (4) @(posedge pclk);
      frame_pulse <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask : frame
   // control write applied at the next frame boundary
   task ctrl(input logic [15:0] v);
      apb(1'b1, ADDR_CTRL, {16'h0000, v});
      frame();
   endtask : ctrl
   // look up one transmit slot; outputs are registered one cycle later
   task look(input logic [11:0] idx);
      @(posedge pclk);
      tx_slot <= idx;
      repeat (2) @(posedge pclk);
   endtask : look
   task final_report();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   // watchdog sized well above the bulk load wait
   initial
   begin
      repeat (60000) @(posedge pclk);
      err_count++;
      $display("Error watchdog expected done seen hang");
      final_report();
   end
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, frame_pulse, output_drive_pin, frame_eval_complete} = 6'h00;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      tx_slot = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h00000000);
      `CHK("ctrl reset", {16'h0000, CTRL_RESET}, rdat)
      apb(1'b0, 16'h000C, 32'h00000000);
      `CHK("unmapped err", 1'b1, rerr)
      `CHK("unmapped data", 32'h00000000, rdat)
      // memory fields reach the datapath unchanged
      cmw(12'h000, 16'h9F15);
      cmr(12'h000);
      `CHK("cm readback", 32'h00009F15, rdat)
      `CHK("mapped err", 1'b0, rerr)
      look(12'h000);
      `CHK("tx_conn", 16'h9F15, tx_conn)
      // control write waits for the frame boundary
      apb(1'b1, ADDR_CTRL, 32'h0000F020);
      apb(1'b0, ADDR_CTRL, 32'h00000000);
      `CHK("ctrl before frame", 32'h00000000, rdat)
      frame();
      apb(1'b0, ADDR_CTRL, 32'h00000000);
      `CHK("ctrl after frame", 32'h00000020, rdat)
      // every rate code, loopback only for the three lowest
      for (int r = 0; r < 16; r++)
      begin
         ctrl(16'h0020 | 16'(r));
         look(12'h000);
         `CHK("rate_select", 4'(r), rate_select)
         `CHK("tx_loop", (r <= 2) ? 1'b1 : 1'b0, tx_loop)
      end
      // output enable from drive pin, standby and channel mode
      cmw(12'h001, 16'h6000);
      cmw(12'h002, 16'h0000);
      ctrl(16'h0000);
      look(12'h002);
      `CHK("oe pin low stby 0", 1'b0, tx_oe)
      ctrl(16'h0020);
      look(12'h002);
      `CHK("oe stby 1", 1'b1, tx_oe)
      look(12'h001);
      `CHK("oe hiz mode", 1'b0, tx_oe)
      ctrl(16'h0000);
      output_drive_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      look(12'h002);
      `CHK("oe pin high", 1'b1, tx_oe)
      look(12'h001);
      `CHK("oe pin high hiz", 1'b0, tx_oe)
      // frame evaluation start and end
      ctrl(16'h0010);
      `CHK("eval run", 1'b1, frame_eval_run)
      frame_eval_complete <= 1'b1;
      @(posedge pclk);
      frame_eval_complete <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK("eval stop", 1'b0, frame_eval_run)
      // begin without arm must not load
      ctrl(16'h0000);
      ctrl(16'h03E0);
      `CHK("no arm busy", 1'b0, bulk_busy)
      cmr(12'h000);
      `CHK("no arm mem", 32'h00009F15, rdat)
      // armed bulk load of value 101
      ctrl(16'h0020);
      apb(1'b1, ADDR_CTRL, 32'h00000AE0);
      frame();
      `CHK("bulk busy", 1'b1, bulk_busy)
      t0 = cyc;
      n = 0;
      do
      begin
         apb(1'b0, ADDR_CTRL, 32'h00000000);
         n++;
      end
      while (rdat[CTRL_BEGIN] !== 1'b0 && n < 15000);
      `CHK("begin clears", 32'h00000AA0, rdat)
      `CHK("two frames", 1'b1, (cyc - t0) > 24900 && (cyc - t0) < 25100)
      cmr(12'h000);
      `CHK("bulk first", 32'h0000A000, rdat)
      cmr(12'(CM_DEPTH - 1));
      `CHK("bulk last", 32'h0000A000, rdat)
      final_report();
   end
endmodule : tsw_ctrl_tb_top
